// ==== rtl/sfw_consts.vh ====
// Constants for the 18-bit synchronous FIFO write-port and reset block
`ifndef SFW_CONSTS_VH
`define SFW_CONSTS_VH
`define SFW_DATA_W       18
`define SFW_DEPTH        256
`define SFW_AW           8
`define SFW_OFS_W        12
`define SFW_DEF_OFS_256  12'h01F
`define SFW_DEF_OFS_512  12'h03F
`define SFW_DEF_OFS_BIG  12'h07F
// Wishbone register offsets (byte addresses)
`define SFW_REG_CTRL     4'h0
`define SFW_REG_STAT     4'h4
`define SFW_REG_EOFS     4'h8
`define SFW_REG_FOFS     4'hC
// Control register fields
`define SFW_CTRL_SRST    0
`define SFW_CTRL_RDEN    1
// Status register fields
`define SFW_ST_EF        0
`define SFW_ST_AE        1
`define SFW_ST_HF        2
`define SFW_ST_AF        3
`define SFW_ST_FF        4
`endif

// ==== rtl/sfw_ram.v ====
// Storage array with one write port and one registered read port
`timescale 1ns/1ps
`default_nettype none
module sfw_ram #(
	parameter DW = 18,
	parameter AW = 8
) (
	input  wire          clk_i,   // Common clock
	input  wire          we_i,    // Write strobe
	input  wire [AW-1:0] waddr_i, // Write address
	input  wire [DW-1:0] wdata_i, // Write data
	input  wire [AW-1:0] raddr_i, // Read address
	output reg  [DW-1:0] rdata_o  // Read data, one cycle later
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// Array write and synchronous read
	always @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule
`default_nettype wire

// ==== rtl/sfw_fifo.v ====
// Synchronous FIFO core: reset behaviour, write port, flags and registers
//
// What this block does
// - Write bus carries a full 18-bit word on every write.
// - Reset state entered whenever the active-low reset is low.
// - Reset returns read and write pointers to the first location.
// - Reset drives full, half-full and almost-full flags high.
// - Reset drives empty and almost-empty flags low.
// - Reset clears every output register bit to zero.
// - Reset reloads both offset registers with built-in defaults.
// - Each write samples its data on the rising clock edge.
// - Works with write and read on one common clock.
// - Default almost-empty offset: 31, 63 or 127 by depth.
// - Default almost-full offset: 31, 63 or 127 by depth.
// - Half-full flag low while more than half full.
`include "sfw_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module sfw_fifo #(
	parameter DW    = `SFW_DATA_W,
	parameter DEPTH = `SFW_DEPTH,
	parameter AW    = `SFW_AW
) (
	input  wire          clk_i,                // 20 MHz clock, write and read share it
	input  wire          rst_i,                // Synchronous active-high system reset
	input  wire          reset_n_i,            // Device reset pin, active low
	input  wire [DW-1:0] write_data_bus_i,     // Write data pin bus
	input  wire          wr_en_n_i,            // Write enable pin, active low
	input  wire          rd_en_n_i,            // Read enable pin, active low
	input  wire [3:0]    wb_adr_i,             // Wishbone address
	input  wire [31:0]   wb_dat_i,             // Wishbone write data
	input  wire [3:0]    wb_sel_i,             // Wishbone byte selects
	input  wire          wb_we_i,              // Wishbone write
	input  wire          wb_cyc_i,             // Wishbone cycle
	input  wire          wb_stb_i,             // Wishbone strobe
	output reg  [31:0]   wb_dat_o,             // Wishbone read data
	output reg           wb_ack_o,             // Wishbone acknowledge
	output reg  [DW-1:0] read_data_o,          // Read-side output register
	output reg           full_flag_n_o,        // Full flag, low when full
	output reg           half_full_flag_n_o,   // Low when above half full
	output reg           almost_full_flag_n_o, // Low when almost full
	output reg           empty_flag_n_o,       // Low when empty
	output reg           almost_empty_flag_n_o // Low when almost empty
);
	// ************************************************************
	// Default offsets chosen from depth
	// ************************************************************
	localparam [`SFW_OFS_W-1:0] DEF_OFS = (DEPTH <= 256) ? `SFW_DEF_OFS_256 :
		(DEPTH <= 512) ? `SFW_DEF_OFS_512 : `SFW_DEF_OFS_BIG;
	localparam [AW:0] HALF = DEPTH / 2;
	localparam [AW:0] FULL = DEPTH;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	reg [DW-1:0] wd_s1_ff;
	reg [DW-1:0] wd_s2_ff;
	reg [2:0]    ctl_s1_ff;
	reg [2:0]    ctl_s2_ff;

	// Two stages before any logic sees a pin
	always @(posedge clk_i) begin
		wd_s1_ff  <= write_data_bus_i;
		wd_s2_ff  <= wd_s1_ff;
		ctl_s1_ff <= {reset_n_i, wr_en_n_i, rd_en_n_i};
		ctl_s2_ff <= ctl_s1_ff;
	end

	wire pin_rst_n = ctl_s2_ff[2];
	wire pin_wen_n = ctl_s2_ff[1];
	wire pin_ren_n = ctl_s2_ff[0];

	// ************************************************************
	// Registers visible over the bus
	// ************************************************************
	reg                  soft_rst_ff;
	reg                  bus_rden_ff;
	reg [`SFW_OFS_W-1:0] empty_ofs_ff;
	reg [`SFW_OFS_W-1:0] full_ofs_ff;
	reg                  inited_ff;

	// Device reset: pin low, software reset bit, or system reset
	wire dev_rst = rst_i | ~pin_rst_n | soft_rst_ff;

	// ************************************************************
	// Pointers and count
	// ************************************************************
	reg [AW-1:0] wptr_ff;
	reg [AW-1:0] rptr_ff;
	reg [AW:0]   cnt_ff;
	reg          rd_pend_ff;
	wire [DW-1:0] ram_q;

	// Writes are refused until a reset has been seen after power-up
	wire do_wr = inited_ff & ~pin_wen_n & (cnt_ff != FULL);
	wire rd_req = ~pin_ren_n | bus_rden_ff;
	wire do_rd = inited_ff & rd_req & (cnt_ff != {(AW+1){1'b0}});

	wire [AW:0] nxt_cnt = cnt_ff + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};

	sfw_ram #(
		.DW (DW),
		.AW (AW)
	) u_ram (
		.clk_i   (clk_i),
		.we_i    (do_wr),
		.waddr_i (wptr_ff),
		.wdata_i (wd_s2_ff),
		.raddr_i (rptr_ff),
		.rdata_o (ram_q)
	);

	// Pointer and count update; shared clock keeps read and write coherent
	always @(posedge clk_i) begin
		if (dev_rst) begin
			wptr_ff    <= {AW{1'b0}};
			rptr_ff    <= {AW{1'b0}};
			cnt_ff     <= {(AW+1){1'b0}};
			rd_pend_ff <= 1'b0;
		end else begin
			if (do_wr) begin
				wptr_ff <= wptr_ff + {{(AW-1){1'b0}}, 1'b1};
			end
			if (do_rd) begin
				rptr_ff <= rptr_ff + {{(AW-1){1'b0}}, 1'b1};
			end
			cnt_ff     <= nxt_cnt;
			rd_pend_ff <= do_rd;
		end
	end

	// ************************************************************
	// Output register
	// ************************************************************
	always @(posedge clk_i) begin
		if (dev_rst) begin
			read_data_o <= {DW{1'b0}};
		end else if (rd_pend_ff) begin
			read_data_o <= ram_q;
		end
	end

	// ************************************************************
	// Flags, registered from the next count
	// ************************************************************
	always @(posedge clk_i) begin
		if (dev_rst) begin
			full_flag_n_o         <= 1'b1;
			half_full_flag_n_o    <= 1'b1;
			almost_full_flag_n_o  <= 1'b1;
			empty_flag_n_o        <= 1'b0;
			almost_empty_flag_n_o <= 1'b0;
		end else begin
			full_flag_n_o         <= (nxt_cnt != FULL);
			half_full_flag_n_o    <= ~(nxt_cnt > HALF);
			almost_full_flag_n_o  <= ~(nxt_cnt >= FULL - full_ofs_ff[AW:0]);
			empty_flag_n_o        <= (nxt_cnt != {(AW+1){1'b0}});
			almost_empty_flag_n_o <= ~(nxt_cnt <= empty_ofs_ff[AW:0]);
		end
	end

	// ************************************************************
	// Offset registers and power-up tracking
	// ************************************************************
	wire bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;

	// Offsets default at reset; software may rewrite them afterwards
	always @(posedge clk_i) begin
		// Any device reset, the system reset included, arms the write port
		if (dev_rst) begin
			inited_ff <= 1'b1;
		end
		if (dev_rst) begin
			empty_ofs_ff <= DEF_OFS;
			full_ofs_ff  <= DEF_OFS;
		end else if (bus_wr) begin
			if (wb_adr_i == `SFW_REG_EOFS) begin
				if (wb_sel_i[0]) empty_ofs_ff[7:0]  <= wb_dat_i[7:0];
				if (wb_sel_i[1]) empty_ofs_ff[11:8] <= wb_dat_i[11:8];
			end
			if (wb_adr_i == `SFW_REG_FOFS) begin
				if (wb_sel_i[0]) full_ofs_ff[7:0]  <= wb_dat_i[7:0];
				if (wb_sel_i[1]) full_ofs_ff[11:8] <= wb_dat_i[11:8];
			end
		end
	end

	// Control register: soft reset self-clears after one cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			soft_rst_ff <= 1'b0;
			bus_rden_ff <= 1'b0;
		end else begin
			soft_rst_ff <= 1'b0;
			if (bus_wr && wb_adr_i == `SFW_REG_CTRL && wb_sel_i[0]) begin
				soft_rst_ff <= wb_dat_i[`SFW_CTRL_SRST];
				bus_rden_ff <= wb_dat_i[`SFW_CTRL_RDEN];
			end
		end
	end

	// ************************************************************
	// Wishbone slave: ack one cycle after strobe, unmapped reads zero
	// ************************************************************
	reg [31:0] nxt_dat;

	always @* begin
		nxt_dat = 32'h0000_0000;
		case (wb_adr_i)
		`SFW_REG_CTRL: begin
			nxt_dat[`SFW_CTRL_RDEN] = bus_rden_ff;
		end
		`SFW_REG_STAT: begin
			nxt_dat[`SFW_ST_EF] = empty_flag_n_o;
			nxt_dat[`SFW_ST_AE] = almost_empty_flag_n_o;
			nxt_dat[`SFW_ST_HF] = half_full_flag_n_o;
			nxt_dat[`SFW_ST_AF] = almost_full_flag_n_o;
			nxt_dat[`SFW_ST_FF] = full_flag_n_o;
			nxt_dat[16 +: AW+1] = cnt_ff;
		end
		`SFW_REG_EOFS: begin
			nxt_dat[`SFW_OFS_W-1:0] = empty_ofs_ff;
		end
		`SFW_REG_FOFS: begin
			nxt_dat[`SFW_OFS_W-1:0] = full_ofs_ff;
		end
		default: begin
			nxt_dat = 32'h0000_0000;
		end
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			wb_dat_o <= nxt_dat;
		end
	end
endmodule
`default_nettype wire

// ==== dv/sfw_checker.sv ====
// Port checker for the FIFO block
`timescale 1ns/1ps
`default_nettype none
module sfw_checker #(parameter DW = 18) (
	input wire logic          clk_i,                // Clock
	input wire logic          rst_i,                // Reset
	input wire logic          reset_n_i,            // Pin reset
	input wire logic          wr_en_n_i,            // Write
	input wire logic          rd_en_n_i,            // Read
	input wire logic          wb_cyc_i,             // Cycle
	input wire logic          wb_stb_i,             // Strobe
	input wire logic          wb_ack_o,             // Ack
	input wire logic [DW-1:0] read_data_o,          // Word out
	input wire logic          full_flag_n_o,        // Full
	input wire logic          half_full_flag_n_o,   // Half
	input wire logic          almost_full_flag_n_o, // Near full
	input wire logic          empty_flag_n_o,       // Empty
	input wire logic          almost_empty_flag_n_o // Near empty
);
	// ****
	// Properties
	// ****
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Pin low two edges, then three edges for sync and register
	sequence s_pin_rst;
		!reset_n_i [*2] ##3 1'b1;
	endsequence
	// Write into empty with no reads and no reset in flight
	sequence s_wr_empty;
		reset_n_i [*4] ##0 (!wr_en_n_i && rd_en_n_i && !empty_flag_n_o)
		##1 (rd_en_n_i && reset_n_i) [*6];
	endsequence
	a_rst_high:
		assert property (s_pin_rst |-> full_flag_n_o && half_full_flag_n_o
			&& almost_full_flag_n_o) else $error("flag not high");
	a_rst_low:
		assert property (s_pin_rst |-> !empty_flag_n_o && !almost_empty_flag_n_o)
			else $error("flag not low");
	a_rst_zero:
		assert property (s_pin_rst |-> read_data_o == '0) else $error("out not zero");
	a_wr_store:
		assert property (s_wr_empty |-> empty_flag_n_o) else $error("write lost");
	a_full_hold:
		assert property ((!full_flag_n_o && rd_en_n_i && reset_n_i) [*4] |=> !full_flag_n_o)
			else $error("full left");
	a_full_half:
		assert property (!full_flag_n_o [*2] |-> !half_full_flag_n_o && !almost_full_flag_n_o)
			else $error("half flag");
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
endmodule
`default_nettype wire

// ==== dv/sfw_far.sv ====
// Model of the upstream writer and downstream reader
`timescale 1ns/1ps
`default_nettype none
module sfw_far #(parameter DW = 18) (
	input  wire logic          clk_i,   // Clock
	input  wire logic [DW-1:0] q_i,     // Word out
	output var  logic [DW-1:0] data_o,  // Write word
	output var  logic          wen_n_o, // Write enable
	output var  logic          ren_n_o  // Read enable
);
	// Idle pins
	initial begin
		data_o = '0;
		wen_n_o = 1'b1;
		ren_n_o = 1'b1;
	end
	// One whole word; after a nonzero gap the bus parks at the inverse so stale data never matches
	task automatic put(input logic [DW-1:0] w, input int gap);
		@(posedge clk_i);
		data_o  <= w;
		wen_n_o <= 1'b0;
		repeat (gap) begin
			@(posedge clk_i);
			wen_n_o <= 1'b1;
			data_o  <= ~w;
		end
	endtask
	// One read; word settles after sync and output register
	task automatic get(output logic [DW-1:0] w);
		@(posedge clk_i);
		ren_n_o <= 1'b0;
		@(posedge clk_i);
		ren_n_o <= 1'b1;
		repeat (6) @(posedge clk_i);
		w = q_i;
	endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for FIFO reset and write port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam DW = 18;
	logic          clk_i = 1'b0;
	logic          rst_i = 1'b1;
	logic          reset_n_i = 1'b1;
	logic [3:0]    wb_adr_i = 4'h0;
	logic [31:0]   wb_dat_i = 32'h0, wb_dat_o, d;
	logic [3:0]    wb_sel_i = 4'hF;
	logic          wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
	logic [DW-1:0] write_data_bus_i, read_data_o, q;
	logic          wr_en_n_i, rd_en_n_i, full_flag_n_o, half_full_flag_n_o;
	logic          almost_full_flag_n_o, empty_flag_n_o, almost_empty_flag_n_o;
	int            miscompares = 0, n_tests = 0;
	// One clock for both sides
	always #25 clk_i = ~clk_i;
	sfw_fifo i_dut (.*);
	sfw_far i_far (.clk_i, .q_i(read_data_o), .data_o(write_data_bus_i),
		.wen_n_o(wr_en_n_i), .ren_n_o(rd_en_n_i));
	// ****
	// Tasks
	// ****
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Classic cycle; ack and data taken at the rising edge, released there
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= v;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk_i);
		end
		if (wb_ack_o !== 1'b1) begin
			miscompares++;
			$display("[FAIL] %0t no bus ack", $time);
		end
		d = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic finish_test;
		$display("Checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ****
	// Tests
	// ****
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, 4'h4, 0);
		chk(d, 32'h0000001C);
		wb(1, 4'h8, 5);
		wb(0, 4'hC, 0);
		chk(d, 32'h1F);
		// Words only after reset; full-width patterns, slow and fast
		i_far.put(18'h2AAAA, 0);
		i_far.put(18'h15555, 1);
		i_far.put(18'h3FFFF, 2);
		i_far.get(q);
		chk(q, 32'h2AAAA);
		i_far.get(q);
		chk(q, 32'h15555);
		i_far.get(q);
		chk(q, 32'h3FFFF);
		i_far.put(18'h01234, 0);
		i_far.put(18'h05678, 1);
		i_far.get(q);
		// Pin reset with data held and the almost-empty offset programmed
		reset_n_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk(read_data_o, 0);
		wb(0, 4'h4, 0);
		chk(d, 32'h0000001C);
		wb(0, 4'h8, 0);
		chk(d, 32'h1F);
		i_far.put(18'h0BEEF, 1);
		i_far.get(q);
		chk(q, 32'h0BEEF);
		// Fill to the last location, then one refused and one wrapped
		for (int i = 0; i < 256; i++)
			i_far.put(18'h2A5A5 ^ 18'(i), i / 255);
		repeat (6) @(posedge clk_i);
		wb(0, 4'h4, 0);
		chk(d, 32'h01000003);
		i_far.put(18'h3ABCD, 1);
		i_far.get(q);
		chk(q, 32'h2A5A5);
		i_far.put(18'h3ABCD, 1);
		for (int i = 1; i < 257; i++) begin
			i_far.get(q);
			chk(q, i < 256 ? 32'(18'h2A5A5 ^ 18'(i)) : 32'h3ABCD);
		end
		// Software reset with a word stored empties the FIFO again
		i_far.put(18'h1C3C3, 1);
		repeat (8) @(posedge clk_i);
		wb(1, 4'h0, 1);
		repeat (4) @(posedge clk_i);
		wb(0, 4'h4, 0);
		chk(d, 32'h0000001C);
		chk(read_data_o, 0);
		finish_test;
	end
	// Run takes under 6000 cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		finish_test;
	end
endmodule
bind sfw_fifo sfw_checker #(.DW(DW)) i_chk (.*);
`default_nettype wire
